/* File: hdl/pwc_io_wake.sv */
`timescale 1ns/100ps
`default_nettype none
module pwc_io_wake #(
    parameter int W = 8
) (
    input wire logic clk, // core clock
    input wire logic rst_b, // async reset, active low
    input wire logic [W-1:0] pin_in, // pin levels
    input wire logic [W-1:0] out_latch, // output register
    input wire logic [W-1:0] wake_en, // per-pin enable
    input wire logic [W-1:0] is_output, // pin driven as output
    output logic match // some enabled input pin matches
);
    // registered so the sequencer sees a clean level
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            match <= 1'b0;
        else
            match <= |(wake_en & ~is_output & ~(pin_in ^ out_latch));
    end
endmodule
`default_nettype wire

/* File: hdl/pwc_pd_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface pwc_pd_if;
    import pwc_pkg::*;
    logic pd_req; // power-down request bit
    logic fast_stop; // fast_osc_stop bit
    logic slow_keep; // slow_osc_keep bit
    logic clk_sel_slow; // resume clock selector
    logic io_wake; // qualified pin match
    logic timer_wake; // qualified timer request
    logic audio_wake; // audio detector event
    pwc_state_t state; // sequencer state
    logic wake_ack; // accepted wake, one cycle
    logic freeze; // core frozen
    logic fast_en; // fast oscillator enable
    logic slow_en; // slow oscillator enable
    logic timer_en; // second timer clock enable
    logic clk_slow; // core runs on slow clock
    modport ctl (output pd_req, fast_stop, slow_keep, clk_sel_slow,
        io_wake, timer_wake, audio_wake, input state, wake_ack,
        freeze, fast_en, slow_en, timer_en, clk_slow);
    modport fsm (input pd_req, fast_stop, slow_keep, clk_sel_slow,
        io_wake, timer_wake, audio_wake, output state, wake_ack,
        freeze, fast_en, slow_en, timer_en, clk_slow);
endinterface
`default_nettype wire

/* File: hdl/pwc_pkg.sv */
package pwc_pkg;
    // power-down sequencer states
    typedef enum logic [1:0] {
        PWC_ACTIVE = 2'b00,
        PWC_SLEEP = 2'b01,
        PWC_IDLE = 2'b10,
        PWC_RESUME = 2'b11
    } pwc_state_t;
    // register byte
    typedef logic [7:0] pwc_byte_t;
endpackage

/* File: hdl/pwc_power_fsm.sv */
`timescale 1ns/100ps
`default_nettype none
module pwc_power_fsm
    import pwc_pkg::*;
(
    input wire logic clk, // core clock
    input wire logic rst_b, // async reset, active low
    pwc_pd_if.fsm pd // request and wake side
);
    pwc_state_t next_state; // state after this edge
    logic asleep; // next state is a power-down state
    // ---------------------------------------------------------
    // next state
    // ---------------------------------------------------------
    always_comb
    begin
        next_state = pd.state;
        pd.wake_ack = 1'b0;
        case (pd.state)
            PWC_ACTIVE:
                if (pd.pd_req)
                    next_state = (pd.fast_stop && !pd.slow_keep) ?
                        PWC_SLEEP : PWC_IDLE;
            PWC_SLEEP:
                if (pd.io_wake)
                begin
                    next_state = PWC_RESUME;
                    pd.wake_ack = 1'b1;
                end
            PWC_IDLE:
                if (pd.io_wake || pd.timer_wake || pd.audio_wake)
                begin
                    next_state = PWC_RESUME;
                    pd.wake_ack = 1'b1;
                end
            default:
                next_state = PWC_ACTIVE;
        endcase
    end
    assign asleep = (next_state == PWC_SLEEP) || (next_state == PWC_IDLE);
    // ---------------------------------------------------------
    // state and clock controls; reset drops any power-down
    // ---------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pd.state <= PWC_ACTIVE;
            pd.freeze <= 1'b0;
            pd.fast_en <= 1'b1;
            pd.slow_en <= 1'b1;
            pd.timer_en <= 1'b1;
            pd.clk_slow <= 1'b0;
        end
        else
        begin
            pd.state <= next_state;
            pd.freeze <= asleep;
            pd.fast_en <= !(asleep && pd.fast_stop);
            pd.slow_en <= (next_state == PWC_SLEEP) ? 1'b0 :
                (next_state == PWC_IDLE) ? pd.slow_keep : 1'b1;
            pd.timer_en <= (next_state != PWC_SLEEP);
            if (!asleep)
                pd.clk_slow <= pd.clk_sel_slow;
        end
    end
endmodule
`default_nettype wire

/* File: hdl/pwc_power_wakeup_control.sv */
`timescale 1ns/100ps
`include "pwc_regs.svh"
`default_nettype none
module pwc_power_wakeup_control
    import pwc_pkg::*;
#(
    parameter int PORT_W = 8
) (
    input wire logic clk, // core clock, 250 MHz
    input wire logic rst_b, // async reset, active low
    input wire logic [7:0] reg_addr, // register address
    input wire logic [7:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [7:0] reg_rdata, // read data, cycle after strobe
    output logic irq, // unmasked wake status pending
    input wire logic [PORT_W-1:0] port0_in, // port 0 pin levels
    output logic [PORT_W-1:0] port0_out, // port 0 drive value
    output logic [PORT_W-1:0] port0_oe_b, // port 0 enable, low drives
    input wire logic [PORT_W-1:0] port1_in, // port 1 pin levels
    output logic [PORT_W-1:0] port1_out, // port 1 drive value
    output logic [PORT_W-1:0] port1_oe_b, // port 1 enable, low drives
    input wire logic second_timer_wake, // timer overflow request
    input wire logic audio_wake, // audio detector event
    output logic [7:0] audio_class_sel, // sound class to detect
    output logic cpu_freeze, // core held frozen
    output logic cpu_clk_slow, // core on slow clock
    output logic fast_osc_en, // fast oscillator enable
    output logic slow_osc_en, // slow oscillator enable
    output logic second_timer_en, // second timer runs
    output logic pdn_pin, // power-down request pin
    output logic ext_bus_oe_b, // external bus enable, low drives
    output logic ext_bus_pullup // weak pull-ups on external bus
);
    // ---------------------------------------------------------
    // register storage
    // ---------------------------------------------------------
    pwc_byte_t clock_power_control; // mode and clock bits
    pwc_byte_t port0_wake_enable; // per-pin wake enable, port 0
    pwc_byte_t port1_wake_enable; // per-pin wake enable, port 1
    pwc_byte_t port0_out_latch; // port 0 output register
    pwc_byte_t port0_ctl_a; // port 0 control A
    pwc_byte_t port0_ctl_b; // port 0 control B
    pwc_byte_t port1_out_latch; // port 1 output register
    pwc_byte_t port1_ctl_a; // port 1 control A
    pwc_byte_t port1_ctl_b; // port 1 control B
    pwc_byte_t wake_status; // sticky events
    pwc_byte_t wake_mask; // interrupt mask
    pwc_byte_t audio_class; // selected sound class
    // ---------------------------------------------------------
    // internal nets
    // ---------------------------------------------------------
    logic [PORT_W-1:0] port0_is_out; // port 0 pins set as outputs
    logic [PORT_W-1:0] port1_is_out; // port 1 pins set as outputs
    logic port0_match; // registered pin match, port 0
    logic port1_match; // registered pin match, port 1
    logic pd_req; // power-down request bit
    logic wake_ack; // accepted wake this cycle
    pwc_byte_t status_set; // events that set status this cycle
    pwc_byte_t status_clr; // write-one-to-clear pattern
    pwc_byte_t next_rdata; // read mux output
    pwc_pd_if pd(); // link to the sequencer

    // ---------------------------------------------------------
    // helpers
    // ---------------------------------------------------------
    // write hit on one register address
    function automatic logic wr_hit(input logic [7:0] a);
        return reg_wr && (reg_addr == a);
    endfunction

    // output direction: both control bits high makes an output
    function automatic logic [PORT_W-1:0] out_mode(
        input logic [PORT_W-1:0] a,
        input logic [PORT_W-1:0] b);
        return a & b;
    endfunction

    // ---------------------------------------------------------
    // clock_power_control
    // ---------------------------------------------------------
    // hardware clears the request bit when a wake is accepted;
    // the core is frozen then, so no write competes with it
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            clock_power_control <= `PWC_CPC_RST;
        else if (wake_ack)
            clock_power_control[`PWC_CPC_PDN] <= 1'b0;
        else if (wr_hit(`PWC_CPC_ADDR))
            clock_power_control <= reg_wdata & `PWC_CPC_WMASK;
    end

    assign pd_req = clock_power_control[`PWC_CPC_PDN];

    // ---------------------------------------------------------
    // wake enable registers
    // ---------------------------------------------------------
    // one register per port, one bit per pin
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            port0_wake_enable <= `PWC_REG_RST;
            port1_wake_enable <= `PWC_REG_RST;
        end
        else
        begin
            if (wr_hit(`PWC_P0WE_ADDR))
                port0_wake_enable <= reg_wdata;
            if (wr_hit(`PWC_P1WE_ADDR))
                port1_wake_enable <= reg_wdata;
        end
    end

    // ---------------------------------------------------------
    // port output and control registers
    // ---------------------------------------------------------
    // the output latch doubles as the wake polarity level
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            port0_out_latch <= `PWC_REG_RST;
            port0_ctl_a <= `PWC_REG_RST;
            port0_ctl_b <= `PWC_REG_RST;
            port1_out_latch <= `PWC_REG_RST;
            port1_ctl_a <= `PWC_REG_RST;
            port1_ctl_b <= `PWC_REG_RST;
        end
        else
        begin
            if (wr_hit(`PWC_P0OUT_ADDR))
                port0_out_latch <= reg_wdata;
            if (wr_hit(`PWC_P0CA_ADDR))
                port0_ctl_a <= reg_wdata;
            if (wr_hit(`PWC_P0CB_ADDR))
                port0_ctl_b <= reg_wdata;
            if (wr_hit(`PWC_P1OUT_ADDR))
                port1_out_latch <= reg_wdata;
            if (wr_hit(`PWC_P1CA_ADDR))
                port1_ctl_a <= reg_wdata;
            if (wr_hit(`PWC_P1CB_ADDR))
                port1_ctl_b <= reg_wdata;
        end
    end

    // ---------------------------------------------------------
    // pin drive
    // ---------------------------------------------------------
    // the latch value always sits on the data line; only the
    // enable decides whether it reaches the pin
    assign port0_is_out = out_mode(port0_ctl_a, port0_ctl_b);
    assign port1_is_out = out_mode(port1_ctl_a, port1_ctl_b);
    assign port0_out = port0_out_latch;
    assign port1_out = port1_out_latch;
    assign port0_oe_b = ~port0_is_out;
    assign port1_oe_b = ~port1_is_out;

    // ---------------------------------------------------------
    // audio class and interrupt mask
    // ---------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            audio_class <= `PWC_REG_RST;
            wake_mask <= `PWC_REG_RST;
        end
        else
        begin
            if (wr_hit(`PWC_ACLS_ADDR))
                audio_class <= reg_wdata;
            if (wr_hit(`PWC_MASK_ADDR))
                wake_mask <= reg_wdata;
        end
    end

    assign audio_class_sel = audio_class;

    // ---------------------------------------------------------
    // pin match detectors
    // ---------------------------------------------------------
    pwc_io_wake #(
        .W(PORT_W)
    ) u_port0_wake (
        .clk(clk),
        .rst_b(rst_b),
        .pin_in(port0_in),
        .out_latch(port0_out_latch),
        .wake_en(port0_wake_enable),
        .is_output(port0_is_out),
        .match(port0_match)
    );

    pwc_io_wake #(
        .W(PORT_W)
    ) u_port1_wake (
        .clk(clk),
        .rst_b(rst_b),
        .pin_in(port1_in),
        .out_latch(port1_out_latch),
        .wake_en(port1_wake_enable),
        .is_output(port1_is_out),
        .match(port1_match)
    );

    // ---------------------------------------------------------
    // sequencer hookup
    // ---------------------------------------------------------
    // the timer request only counts while its enable bit is set;
    // a request flag left high by software is taken again as a level and wakes idle at once
    assign pd.pd_req = pd_req;
    assign pd.fast_stop = clock_power_control[`PWC_CPC_FSTOP];
    assign pd.slow_keep = clock_power_control[`PWC_CPC_SKEEP];
    assign pd.clk_sel_slow = clock_power_control[`PWC_CPC_CKSEL];
    assign pd.io_wake = port0_match || port1_match;
    assign pd.timer_wake = second_timer_wake &&
        clock_power_control[`PWC_CPC_TWAKE];
    assign pd.audio_wake = audio_wake;
    assign wake_ack = pd.wake_ack;

    pwc_power_fsm u_fsm (
        .clk(clk),
        .rst_b(rst_b),
        .pd(pd)
    );

    // ---------------------------------------------------------
    // power outputs
    // ---------------------------------------------------------
    assign cpu_freeze = pd.freeze;
    assign cpu_clk_slow = pd.clk_slow;
    assign fast_osc_en = pd.fast_en;
    assign slow_osc_en = pd.slow_en;
    assign second_timer_en = pd.timer_en;
    assign pdn_pin = pd_req;
    // bus released and pulled high for as long as pdn stands
    assign ext_bus_oe_b = pd_req;
    assign ext_bus_pullup = pd_req;

    // ---------------------------------------------------------
    // wake status and interrupt
    // ---------------------------------------------------------
    // each source is recorded only when its wake is accepted,
    // so a source that the current mode ignores leaves no mark
    always_comb
    begin
        status_set = 8'h00;
        status_set[`PWC_ST_IO] = wake_ack && pd.io_wake;
        status_set[`PWC_ST_TMR] = wake_ack && pd.timer_wake &&
            (pd.state == PWC_IDLE);
        status_set[`PWC_ST_AUD] = wake_ack && pd.audio_wake &&
            (pd.state == PWC_IDLE);
        status_set[`PWC_ST_PDN] = (pd.state == PWC_ACTIVE) && pd_req;
    end

    assign status_clr = wr_hit(`PWC_STAT_ADDR) ? reg_wdata : 8'h00;

    // set beats a clear that lands in the same cycle
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            wake_status <= `PWC_REG_RST;
        else
            wake_status <= (wake_status & ~status_clr) | status_set;
    end

    assign irq = |(wake_status & wake_mask);

    // ---------------------------------------------------------
    // read path
    // ---------------------------------------------------------
    // pin inputs read straight from the pins at read time
    always_comb
    begin
        if (reg_addr == `PWC_CPC_ADDR)
            next_rdata = clock_power_control;
        else if (reg_addr == `PWC_P0WE_ADDR)
            next_rdata = port0_wake_enable;
        else if (reg_addr == `PWC_P1WE_ADDR)
            next_rdata = port1_wake_enable;
        else if (reg_addr == `PWC_P0OUT_ADDR)
            next_rdata = port0_out_latch;
        else if (reg_addr == `PWC_P0IN_ADDR)
            next_rdata = port0_in;
        else if (reg_addr == `PWC_P0CA_ADDR)
            next_rdata = port0_ctl_a;
        else if (reg_addr == `PWC_P0CB_ADDR)
            next_rdata = port0_ctl_b;
        else if (reg_addr == `PWC_P1OUT_ADDR)
            next_rdata = port1_out_latch;
        else if (reg_addr == `PWC_P1IN_ADDR)
            next_rdata = port1_in;
        else if (reg_addr == `PWC_P1CA_ADDR)
            next_rdata = port1_ctl_a;
        else if (reg_addr == `PWC_P1CB_ADDR)
            next_rdata = port1_ctl_b;
        else if (reg_addr == `PWC_STAT_ADDR)
            next_rdata = wake_status;
        else if (reg_addr == `PWC_MASK_ADDR)
            next_rdata = wake_mask;
        else if (reg_addr == `PWC_ACLS_ADDR)
            next_rdata = audio_class;
        else
            next_rdata = 8'h00; // unmapped reads as zero
    end

    // data stands for one cycle after the strobe, else zero
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            reg_rdata <= 8'h00;
        else if (reg_rd)
            reg_rdata <= next_rdata;
        else
            reg_rdata <= 8'h00;
    end
endmodule
`default_nettype wire

/* File: hdl/pwc_regs.svh */
`ifndef PWC_REGS_SVH
`define PWC_REGS_SVH
// ---------------------------------------------------------
// register offsets
// ---------------------------------------------------------
`define PWC_CPC_ADDR 8'hE8
`define PWC_P0WE_ADDR 8'hE9
`define PWC_P1WE_ADDR 8'hEA
`define PWC_P0OUT_ADDR 8'hE4
`define PWC_P0IN_ADDR 8'hE5
`define PWC_P0CA_ADDR 8'hE6
`define PWC_P0CB_ADDR 8'hE7
`define PWC_P1OUT_ADDR 8'hE0
`define PWC_P1IN_ADDR 8'hE1
`define PWC_P1CA_ADDR 8'hE2
`define PWC_P1CB_ADDR 8'hE3
`define PWC_STAT_ADDR 8'hD0
`define PWC_MASK_ADDR 8'hD1
`define PWC_ACLS_ADDR 8'hD2
// ---------------------------------------------------------
// clock_power_control fields, reset values
// ---------------------------------------------------------
`define PWC_CPC_PDN 7
`define PWC_CPC_TWAKE 6
`define PWC_CPC_CKSEL 2
`define PWC_CPC_SKEEP 1
`define PWC_CPC_FSTOP 0
`define PWC_CPC_WMASK 8'hC7
`define PWC_CPC_RST 8'h00
`define PWC_REG_RST 8'h00
// wake status bits
`define PWC_ST_IO 0
`define PWC_ST_TMR 1
`define PWC_ST_AUD 2
`define PWC_ST_PDN 3
`endif

/* File: testbench/pwc_far_model.sv */
`timescale 1ns/100ps
`default_nettype none
module pwc_far_model #(
    parameter int W = 8
) (
    input wire logic [W-1:0] out0, // port 0 latch
    input wire logic [W-1:0] oe0_b, // port 0 enables, low drives
    input wire logic [W-1:0] ext0, // outside level, pull-up idle
    input wire logic [W-1:0] out1, // port 1 latch
    input wire logic [W-1:0] oe1_b, // port 1 enables
    input wire logic [W-1:0] ext1, // outside level
    input wire logic [1:0] fire, // bench: 0 audio, 1 timer
    input wire logic tmr_run, // timer clock enabled
    output logic [W-1:0] pin0, // resolved port 0 level
    output logic [W-1:0] pin1, // resolved port 1 level
    output logic tmr_req, // overflow request
    output logic aud_evt // detector event
);
    // ---------------------------------------------
    // pins, timer and detector
    // ---------------------------------------------
    // a driven pin shows its latch, else the outside level
    assign pin0 = (~oe0_b & out0) | (oe0_b & ext0);
    assign pin1 = (~oe1_b & out1) | (oe1_b & ext1);
    // flag cleared before power-down, so each overflow is fresh;
    // a stopped timer cannot overflow
    assign tmr_req = fire[1] & tmr_run;
    // analog parked by software; only the event is modelled
    assign aud_evt = fire[0];
endmodule
`default_nettype wire

/* File: testbench/pwc_props.sv */
`timescale 1ns/100ps
`default_nettype none
module pwc_props (
    input wire logic clk, // core clock
    input wire logic rst_b, // async reset, active low
    input wire logic reg_rd, // read strobe
    input wire logic [7:0] reg_rdata, // read data
    input wire logic cpu_freeze, // core frozen
    input wire logic fast_osc_en, // fast osc on
    input wire logic slow_osc_en, // slow osc on
    input wire logic second_timer_en, // timer runs
    input wire logic pdn_pin, // request pin
    input wire logic ext_bus_oe_b, // bus released when high
    input wire logic ext_bus_pullup // weak pull-ups
);
    // ---------------------------------------------
    // power-down relations
    // ---------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // bus floats and pulls up exactly while requested
    chk_bus_float: assert property (ext_bus_oe_b == pdn_pin && ext_bus_pullup == pdn_pin)
        else $error("external bus not following request");
    chk_pin_freeze: assert property (cpu_freeze |-> pdn_pin)
        else $error("core frozen without request on pin");
    chk_freeze_next: assert property ($rose(pdn_pin) |=> cpu_freeze)
        else $error("core not frozen after request");
    chk_freeze_lag: assert property ($rose(cpu_freeze) |-> $past(pdn_pin))
        else $error("core froze before request");
    // sleep: no timer means nothing at all runs
    chk_sleep_quiet: assert property (cpu_freeze && !second_timer_en |-> !fast_osc_en && !slow_osc_en)
        else $error("oscillator running in sleep");
    chk_idle_timer: assert property (cpu_freeze && slow_osc_en |-> second_timer_en)
        else $error("timer stopped in idle");
    chk_wake_clocks: assert property ($fell(pdn_pin) |-> !cpu_freeze && fast_osc_en && slow_osc_en)
        else $error("core not resumed at wake");
    // read data only in the cycle after a read
    chk_rdata_idle: assert property (reg_rdata != 8'h00 |-> $past(reg_rd))
        else $error("read data without read");
    cover property ($rose(cpu_freeze) && !second_timer_en);
    cover property ($rose(cpu_freeze) && second_timer_en);
    cover property ($fell(pdn_pin));
endmodule
bind pwc_power_wakeup_control pwc_props pwc_props_i (.clk(clk),
    .rst_b(rst_b), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cpu_freeze(cpu_freeze), .fast_osc_en(fast_osc_en),
    .slow_osc_en(slow_osc_en), .second_timer_en(second_timer_en),
    .pdn_pin(pdn_pin), .ext_bus_oe_b(ext_bus_oe_b),
    .ext_bus_pullup(ext_bus_pullup));
`default_nettype wire

/* File: testbench/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import pwc_pkg::*;
    logic clk = 1'b0; // core clock
    logic rst_b = 1'b0; // reset, active low
    logic [7:0] reg_addr = 8'h00; // bus address
    logic [7:0] reg_wdata = 8'h00; // bus write data
    logic reg_wr = 1'b0; // write strobe
    logic reg_rd = 1'b0; // read strobe
    logic [7:0] ext0 = 8'hFF; // outside levels, pulled up
    logic [7:0] ext1 = 8'hFF; // outside levels, pulled up
    logic [1:0] fire = 2'b00; // audio, timer events
    logic [7:0] reg_rdata, audio_class_sel, p0i, p0o, p0e, p1i, p1o, p1e;
    logic irq, tmr_req, aud_evt, cpu_freeze, cpu_clk_slow, fast_osc_en;
    logic slow_osc_en, second_timer_en, pdn_pin, ext_bus_oe_b;
    logic ext_bus_pullup;
    int fail_count = 0;
    int comparisons = 0;
    logic [7:0] cfg[2] = '{8'h87, 8'hC3}; // idle: audio, timer
    logic [7:0] stx[2] = '{8'h0C, 8'h0A}; // expected status
    always #2 clk = ~clk;
    pwc_power_wakeup_control #(.PORT_W(8)) pwc_power_wakeup_control_i (
        .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq), .port0_in(p0i),
        .port0_out(p0o), .port0_oe_b(p0e), .port1_in(p1i),
        .port1_out(p1o), .port1_oe_b(p1e), .second_timer_wake(tmr_req),
        .audio_wake(aud_evt), .audio_class_sel(audio_class_sel),
        .cpu_freeze(cpu_freeze), .cpu_clk_slow(cpu_clk_slow),
        .fast_osc_en(fast_osc_en), .slow_osc_en(slow_osc_en),
        .second_timer_en(second_timer_en), .pdn_pin(pdn_pin),
        .ext_bus_oe_b(ext_bus_oe_b), .ext_bus_pullup(ext_bus_pullup));
    pwc_far_model #(.W(8)) pwc_far_model_i (.out0(p0o), .oe0_b(p0e),
        .ext0(ext0), .out1(p1o), .oe1_b(p1e), .ext1(ext1), .fire(fire),
        .tmr_run(second_timer_en), .pin0(p0i), .pin1(p1i),
        .tmr_req(tmr_req), .aud_evt(aud_evt));
    // ---------------------------------------------
    // shared helpers
    // ---------------------------------------------
    task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // freeze, fast, slow, timer, pin, bus release, pull-up
    function automatic logic [7:0] flags();
        return {1'b0, cpu_freeze, fast_osc_en, slow_osc_en,
            second_timer_en, pdn_pin, ext_bus_oe_b, ext_bus_pullup};
    endfunction
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk("rdata", reg_rdata, exp);
    endtask
    task automatic sys(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic pulse(logic [1:0] f);
        @(posedge clk);
        fire <= f;
        @(posedge clk);
        fire <= 2'b00;
        sys(3);
    endtask
    // bounded wait; the flag compare after it judges
    task automatic wait_wake();
        for (int n = 0; n < 10 && pdn_pin !== 1'b0; n++)
            sys(1);
    endtask
    task automatic summarize();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ---------------------------------------------
    // scenarios
    // ---------------------------------------------
    task automatic t_regs();
        chk("oe", p0e, 8'hFF);
        chk("p1", p1o ^ p1e, 8'hFF);
        rd(8'h77, 8'h00);
        wr(8'hE9, 8'hA5);
        wr(8'hEA, 8'h5A);
        wr(8'hE8, 8'h3F);
        wr(8'hD2, 8'h3C);
        rd(8'hE9, 8'hA5);
        rd(8'hEA, 8'h5A);
        rd(8'hE8, 8'h07);
        chk("class", audio_class_sel, 8'h3C);
        wr(8'hE8, 8'h00);
        wr(8'hEA, 8'h00);
        wr(8'hD1, 8'h0F);
    endtask
    // sleep ignores audio, wakes on a pin match, keeps context
    task automatic t_sleep();
        wr(8'hE4, 8'h00);
        wr(8'hE9, 8'h01);
        wr(8'hE8, 8'h81);
        sys(2);
        chk("sleep", flags(), 8'h47);
        pulse(2'b01);
        chk("deaf", flags(), 8'h47);
        @(posedge clk) ext0 <= 8'hFE;
        wait_wake();
        chk("woke", flags(), 8'h38);
        rd(8'hE8, 8'h01);
        rd(8'hE9, 8'h01);
        rd(8'hD0, 8'h09);
        rd(8'hE5, 8'hFE);
        chk("irq", {7'h00, irq}, 8'h01);
        wr(8'hD1, 8'h00);
        chk("mask", {7'h00, irq}, 8'h00);
        wr(8'hD1, 8'h0F);
        wr(8'hD0, 8'hFF);
        chk("clr", {7'h00, irq}, 8'h00);
        wr(8'hE9, 8'h00);
        ext0 <= 8'hFF;
    endtask
    // an output pin never wakes; port 1 pin does
    task automatic t_outpin();
        wr(8'hE6, 8'h02);
        wr(8'hE7, 8'h02);
        wr(8'hE4, 8'h02);
        chk("drive", p0e, 8'hFD);
        chk("out", p0o, 8'h02);
        wr(8'hE9, 8'h02);
        wr(8'hEA, 8'h01);
        wr(8'hE8, 8'h81);
        sys(3);
        chk("outpin", flags(), 8'h47);
        @(posedge clk) ext1 <= 8'hFE;
        wait_wake();
        chk("port1", flags(), 8'h38);
        rd(8'hE1, 8'hFE);
        wr(8'hD0, 8'hFF);
        wr(8'hE9, 8'h00);
        wr(8'hEA, 8'h00);
        ext1 <= 8'hFF;
    endtask
    // idle: audio with slow resume, then timer with fast resume
    task automatic t_idle();
        for (int i = 0; i < 2; i++)
        begin
            wr(8'hE8, cfg[i]);
            sys(2);
            chk("idle", flags(), 8'h5F);
            if (i == 0)
            begin
                pulse(2'b10);
                chk("tmr_off", flags(), 8'h5F);
            end
            pulse(i == 0 ? 2'b01 : 2'b10);
            wait_wake();
            chk("resume", flags(), 8'h38);
            chk("clk", {7'h00, cpu_clk_slow}, 8'(1 - i));
            rd(8'hD0, stx[i]);
            wr(8'hD0, 8'hFF);
        end
    endtask
    task automatic t_reset();
        wr(8'hE8, 8'h81);
        sys(2);
        @(posedge clk);
        rst_b <= 1'b0;
        sys(1);
        chk("rst", flags(), 8'h38);
        @(posedge clk);
        rst_b <= 1'b1;
        rd(8'hE8, 8'h00);
        rd(8'hD1, 8'h00);
    endtask
    initial
    begin
        repeat (20000) @(posedge clk);
        fail_count++;
        summarize();
    end
    initial
    begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        t_regs();
        t_sleep();
        t_outpin();
        t_idle();
        t_reset();
        summarize();
    end
endmodule
`default_nettype wire
